// [hdl/prs_hold_if.sv]
`default_nettype none
interface prs_hold_if
  import prs_pkg::*;
  ();
  logic btn_in;
  logic pressed;
  logic released;
  logic [HOLD_W-1:0] hold_sec;

  modport timer (input btn_in, output pressed, output released, output hold_sec);
  modport user (output btn_in, input pressed, input released, input hold_sec);
endinterface
`default_nettype wire

// [hdl/prs_hold_timer.sv]
`default_nettype none
module prs_hold_timer
  import prs_pkg::*;
#(
  parameter int unsigned DEB_CYCLES = DEB_CYCLES_DFLT,
  parameter int unsigned SEC_CYCLES = SEC_CYCLES_DFLT
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Button side
  prs_hold_if.timer hif
);
  localparam int unsigned DW = $clog2(DEB_CYCLES + 1);
  localparam int unsigned SW = $clog2(SEC_CYCLES + 1);

  if (DEB_CYCLES < 1 || SEC_CYCLES < 2)
  begin : g_bad_cfg
    $error("prs_hold_timer: counts too small");
  end

  logic [DW-1:0] deb_cnt;
  logic [SW-1:0] pre_cnt;
  logic stable;
  logic rel;
  logic [HOLD_W-1:0] hold;

  // A press that bounces restarts the filter, so only a steady level is seen.
  wire differ = (hif.btn_in != stable);
  wire deb_done = differ && (deb_cnt == DW'(DEB_CYCLES - 1));
  wire sec_wrap = (pre_cnt == SW'(SEC_CYCLES - 1));
  wire rising = deb_done && hif.btn_in;
  wire [DW-1:0] next_deb_cnt = (differ && !deb_done) ? deb_cnt + 1'b1 : '0;
  wire [SW-1:0] next_pre_cnt = (rising || !stable || sec_wrap) ? '0 : pre_cnt + 1'b1;
  wire [HOLD_W-1:0] next_hold = rising ? '0 :
    (stable && sec_wrap && hold != HOLD_MAX) ? hold + 1'b1 : hold;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      deb_cnt <= '0;
      pre_cnt <= '0;
      stable <= 1'b0;
      rel <= 1'b0;
      hold <= '0;
    end
    else
    begin
      deb_cnt <= next_deb_cnt;
      pre_cnt <= next_pre_cnt;
      stable <= deb_done ? hif.btn_in : stable;
      rel <= deb_done && !hif.btn_in;
      hold <= next_hold;
    end
  end

  assign hif.pressed = stable;
  assign hif.released = rel;
  assign hif.hold_sec = hold;

  a_hold_saturate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    hold <= HOLD_MAX)
    else $error("hold counter ran past its ceiling");
endmodule // prs_hold_timer
`default_nettype wire

// [hdl/prs_pkg.sv]
`default_nettype none
package prs_pkg;
  // Clock and time base.
  localparam int unsigned CLK_PERIOD_NS = 32'h0000_000A;
  localparam longint unsigned SECOND_NS = 64'h0000_0000_3B9A_CA00;
  localparam int unsigned SEC_CYCLES_DFLT = 32'(SECOND_NS / CLK_PERIOD_NS);
  localparam int unsigned DEBOUNCE_MS = 32'h0000_000A;
  localparam int unsigned MS_NS = 32'h000F_4240;
  localparam int unsigned DEB_CYCLES_DFLT = (DEBOUNCE_MS * MS_NS) / CLK_PERIOD_NS;

  // Hold-time thresholds, in whole seconds of pressing.
  localparam int unsigned HOLD_W = 5;
  localparam logic [HOLD_W-1:0] HOLD_CD1 = 5'h01;
  localparam logic [HOLD_W-1:0] HOLD_CLEAR = 5'h05;
  localparam logic [HOLD_W-1:0] HOLD_CD2 = 5'h06;
  localparam logic [HOLD_W-1:0] HOLD_CONFIG = 5'h0A;
  localparam logic [HOLD_W-1:0] HOLD_CD3 = 5'h0B;
  localparam logic [HOLD_W-1:0] HOLD_FACTORY = 5'h0F;
  localparam logic [HOLD_W-1:0] HOLD_MAX = 5'h0F;

  // Startup timing, in seconds.
  localparam logic [HOLD_W-1:0] BOOT_TIMEOUT_S = 5'h1E;
  localparam logic [HOLD_W-1:0] VERSION_S = 5'h02;

  typedef enum logic [1:0] {
    APP_STOP = 2'h0,
    APP_RUN = 2'h1,
    APP_LOGIC_HALT = 2'h2,
    APP_ERROR = 2'h3
  } prs_app_t;

  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_CLEAR = 2'h1,
    ACT_CONFIG = 2'h2,
    ACT_FACTORY = 2'h3
  } prs_act_t;

  typedef enum logic [3:0] {
    DISP_BLANK = 4'h0,
    DISP_SCROLL = 4'h1,
    DISP_VERSION = 4'h2,
    DISP_ADDR = 4'h3,
    DISP_LINK_LOCAL = 4'h4,
    DISP_COUNT = 4'h5,
    DISP_RESET_PEND = 4'h6,
    DISP_CONFIG_PEND = 4'h7,
    DISP_FACTORY_PEND = 4'h8,
    DISP_BOOT_ERR = 4'h9
  } prs_disp_t;

  typedef enum logic [3:0] {
    ST_POWER = 4'h0,
    ST_AUTH = 4'h1,
    ST_BOOT = 4'h3,
    ST_VERSION = 4'h2,
    ST_RUN = 4'h6,
    ST_HALT = 4'h7,
    ST_STORE = 4'h5,
    ST_APPLY = 4'h4,
    ST_RESET = 4'hC,
    ST_FAIL = 4'hD
  } prs_state_t;
endpackage
`default_nettype wire

// [hdl/prs_sequencer.sv]
`default_nettype none
module prs_sequencer
  import prs_pkg::*;
#(
  parameter int unsigned DEB_CYCLES = DEB_CYCLES_DFLT,
  parameter int unsigned SEC_CYCLES = SEC_CYCLES_DFLT,
  parameter logic [3:0] FW_MAJOR = 4'h1,
  parameter logic [7:0] FW_MINOR = 8'h00
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Operator controls
  input wire logic btn_raw,
  input wire logic btn_enable,
  // Startup checks
  input wire logic img_check_done,
  input wire logic img_check_ok,
  input wire logic auth_done,
  input wire logic auth_ok,
  input wire logic os_up,
  // Configuration
  input wire logic addr_assigned,
  input wire logic always_link_local,
  input wire logic [1:0] startup_state,
  input wire logic [31:0] config_addr,
  input wire logic [31:0] link_local_addr,
  // Application handshakes
  input wire logic app_fault,
  input wire logic halt_done,
  input wire logic store_done,
  // Front panel
  output logic err_led,
  output logic [3:0] disp_code,
  output logic [2:0] disp_digit,
  output logic [31:0] disp_value,
  // Application and module control
  output logic [1:0] app_state,
  output logic halt_req,
  output logic store_req,
  output logic cfg_default,
  output logic file_delete,
  output logic module_reset,
  // Event log
  output logic log_valid,
  output logic [1:0] log_code
);
  localparam int unsigned SW = $clog2(SEC_CYCLES + 1);

  if (SEC_CYCLES < 2)
  begin : g_bad_cfg
    $error("prs_sequencer: SEC_CYCLES too small");
  end

  prs_hold_if hif ();

  prs_hold_timer #(
    .DEB_CYCLES(DEB_CYCLES),
    .SEC_CYCLES(SEC_CYCLES)
  ) u_hold (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .hif(hif)
  );

  prs_state_t state;
  prs_state_t next_state;
  prs_act_t act;
  prs_app_t app;
  logic force_stop;
  logic [SW-1:0] pre_cnt;
  logic [HOLD_W-1:0] sec_cnt;

  // A disabled switch masks the button at its source, so no hold time builds up.
  assign hif.btn_in = btn_raw && btn_enable;

  wire [HOLD_W-1:0] hold = hif.hold_sec;
  wire btn_live = hif.pressed && btn_enable;
  wire fire = hif.released && btn_enable && (state == ST_RUN);

  // The deepest code reached before release picks the action.
  wire prs_act_t rel_act = (hold >= HOLD_FACTORY) ? ACT_FACTORY :
                           (hold >= HOLD_CONFIG) ? ACT_CONFIG :
                           (hold >= HOLD_CLEAR) ? ACT_CLEAR : ACT_NONE;
  wire act_go = fire && (rel_act != ACT_NONE);
  wire prs_act_t cur_act = act_go ? rel_act : act;
  wire app_live = (app == APP_RUN) || (app == APP_LOGIC_HALT);
  wire state_chg = (next_state != state);
  wire sec_tick = (pre_cnt == SW'(SEC_CYCLES - 1));

  always_comb
  begin
    next_state = state;
    case (state)
      ST_POWER:
        if (img_check_done)
          next_state = img_check_ok ? ST_AUTH : ST_FAIL;
      ST_AUTH:
        if (auth_done)
          next_state = auth_ok ? ST_BOOT : ST_FAIL;
      ST_BOOT:
        if (os_up)
          next_state = ST_VERSION;
        else if (sec_cnt == BOOT_TIMEOUT_S)
          next_state = ST_FAIL;
      ST_VERSION:
        if (sec_cnt == VERSION_S)
          next_state = ST_RUN;
      ST_RUN:
        if (act_go)
        begin
          if (app_live)
            next_state = ST_HALT;
          else
            next_state = (rel_act == ACT_CLEAR) ? ST_RESET : ST_APPLY;
        end
      ST_HALT:
        if (halt_done)
          next_state = (act == ACT_CLEAR) ? ST_RESET : ST_STORE;
      ST_STORE:
        if (store_done)
          next_state = ST_APPLY;
      ST_APPLY:
        next_state = ST_RESET;
      ST_RESET:
        next_state = ST_POWER;
      ST_FAIL:
        next_state = ST_FAIL;
      default:
        next_state = ST_POWER;
    endcase
  end

  // Application state: set last in startup, stopped by halts and resets.
  wire prs_app_t start_app = force_stop ? APP_STOP : prs_app_t'(startup_state);
  wire prs_app_t next_app =
    (state == ST_VERSION && next_state == ST_RUN) ? start_app :
    (state == ST_RUN && app_fault && !act_go) ? APP_ERROR :
    (state == ST_HALT && halt_done) ? APP_STOP :
    (next_state == ST_RESET && !app_live) ? APP_STOP : app;
  wire next_force_stop = (next_state == ST_APPLY) ? 1'b1 :
    (state == ST_VERSION && next_state == ST_RUN) ? 1'b0 : force_stop;

  // Front panel selection.
  wire in_count1 = (hold >= HOLD_CD1) && (hold < HOLD_CLEAR);
  wire in_count2 = (hold >= HOLD_CD2) && (hold < HOLD_CONFIG);
  wire in_count3 = (hold >= HOLD_CD3) && (hold < HOLD_FACTORY);
  wire [HOLD_W-1:0] cd_base = in_count1 ? HOLD_CLEAR : in_count2 ? HOLD_CONFIG : HOLD_FACTORY;
  wire [HOLD_W-1:0] cd_left = cd_base - hold;
  wire use_link_local = !addr_assigned || always_link_local;
  wire prs_disp_t run_disp =
    (btn_live && (in_count1 || in_count2 || in_count3)) ? DISP_COUNT :
    (btn_live && hold >= HOLD_FACTORY) ? DISP_FACTORY_PEND :
    (btn_live && hold >= HOLD_CONFIG) ? DISP_CONFIG_PEND :
    (btn_live && hold >= HOLD_CLEAR) ? DISP_RESET_PEND :
    use_link_local ? DISP_LINK_LOCAL : DISP_ADDR;
  wire prs_disp_t next_disp =
    (next_state == ST_BOOT) ? DISP_SCROLL :
    (next_state == ST_VERSION) ? DISP_VERSION :
    (next_state == ST_RUN) ? run_disp :
    (state == ST_BOOT && next_state == ST_FAIL) ? DISP_BOOT_ERR :
    (next_state == ST_FAIL) ? prs_disp_t'(disp_code) : DISP_BLANK;
  wire [31:0] next_value =
    (next_disp == DISP_VERSION) ? {20'h00000, FW_MAJOR, FW_MINOR} :
    (next_disp == DISP_LINK_LOCAL) ? link_local_addr :
    (next_disp == DISP_ADDR) ? config_addr : 32'h0000_0000;
  wire next_led = (next_state == ST_POWER) || (next_state == ST_AUTH) || (next_state == ST_FAIL);

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= ST_POWER;
      act <= ACT_NONE;
      app <= APP_STOP;
      force_stop <= 1'b0;
      pre_cnt <= '0;
      sec_cnt <= '0;
    end
    else
    begin
      state <= next_state;
      act <= cur_act;
      app <= next_app;
      force_stop <= next_force_stop;
      pre_cnt <= (state_chg || sec_tick) ? '0 : pre_cnt + 1'b1;
      // Stage seconds stop at the boot limit, the longest stage that is timed.
      sec_cnt <= state_chg ? '0 : (sec_tick && sec_cnt != BOOT_TIMEOUT_S) ? sec_cnt + 1'b1 : sec_cnt;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      err_led <= 1'b1;
      disp_code <= DISP_BLANK;
      disp_digit <= 3'h0;
      disp_value <= 32'h0000_0000;
      app_state <= APP_STOP;
      halt_req <= 1'b0;
      store_req <= 1'b0;
      cfg_default <= 1'b0;
      file_delete <= 1'b0;
      module_reset <= 1'b0;
      log_valid <= 1'b0;
      log_code <= ACT_NONE;
    end
    else
    begin
      err_led <= next_led;
      disp_code <= next_disp;
      disp_digit <= (next_disp == DISP_COUNT) ? cd_left[2:0] : 3'h0;
      disp_value <= next_value;
      app_state <= next_app;
      halt_req <= (next_state == ST_HALT);
      store_req <= (next_state == ST_STORE);
      cfg_default <= (next_state == ST_APPLY);
      file_delete <= (next_state == ST_APPLY) && (cur_act == ACT_FACTORY);
      module_reset <= (next_state == ST_RESET);
      log_valid <= fire;
      log_code <= rel_act;
    end
  end

  sequence s_release_clear;
    log_valid && log_code == ACT_CLEAR;
  endsequence

  sequence s_release_none;
    log_valid && log_code == ACT_NONE;
  endsequence

  sequence s_enter_run;
    $past(state) == ST_VERSION ##0 state == ST_RUN;
  endsequence

  a_switch_gates_log: assert property (@(posedge clk_sys) disable iff (sys_rst)
    log_valid |-> $past(btn_enable))
    else $error("log entry while the button was disabled");

  a_switch_masks_press: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !btn_enable && !hif.pressed |=> !hif.pressed)
    else $error("press seen while the button was disabled");

  a_clear_resets: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_release_clear |-> (state == ST_HALT || state == ST_RESET))
    else $error("clear release did not head for reset");

  a_reset_one_cycle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    module_reset |=> !module_reset && err_led)
    else $error("module reset did not restart at power stage");

  a_count_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
    disp_code == DISP_COUNT |-> (disp_digit >= 3'h1 && disp_digit <= 3'h4))
    else $error("countdown digit out of range");

  a_abort_no_action: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_release_none |-> state == ST_RUN)
    else $error("aborted press started an action");

  a_reset_pend_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (next_state == ST_RUN && btn_live && hold == HOLD_CLEAR) |=> disp_code == DISP_RESET_PEND)
    else $error("pending reset code not shown");

  a_halt_before_reset: assert property (@(posedge clk_sys) disable iff (sys_rst)
    module_reset |-> !(app_state == APP_RUN || app_state == APP_LOGIC_HALT))
    else $error("module reset with application live");

  a_config_path: assert property (@(posedge clk_sys) disable iff (sys_rst)
    log_valid && log_code == ACT_CONFIG |-> (state == ST_HALT || state == ST_APPLY))
    else $error("configuration release took a wrong path");

  a_config_pend_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (next_state == ST_RUN && btn_live && hold == HOLD_CONFIG) |=> disp_code == DISP_CONFIG_PEND)
    else $error("pending configuration code not shown");

  a_config_stops_app: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cfg_default |-> force_stop ##1 module_reset)
    else $error("configuration reset did not force stop and reset");

  a_stopped_after_cfg: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_enter_run ##0 $past(force_stop) |-> app_state == APP_STOP)
    else $error("application not stopped after configuration reset");

  a_store_then_apply: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cfg_default && $past(state) == ST_STORE |-> $past(store_req))
    else $error("defaults applied without storing data");

  a_halt_then_store: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(store_req) |-> $past(halt_req))
    else $error("data stored without halting first");

  a_factory_delete: assert property (@(posedge clk_sys) disable iff (sys_rst)
    file_delete |-> cfg_default)
    else $error("files deleted without configuration defaults");

  a_factory_path: assert property (@(posedge clk_sys) disable iff (sys_rst)
    log_valid && log_code == ACT_FACTORY |-> (state == ST_HALT || state == ST_APPLY) && act == ACT_FACTORY)
    else $error("factory release took a wrong path");

  a_factory_pend_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (next_state == ST_RUN && btn_live && hold >= HOLD_FACTORY) |=> disp_code == DISP_FACTORY_PEND)
    else $error("pending factory code not shown");

  a_fail_led_on: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == ST_FAIL |-> err_led)
    else $error("halted startup with indicator off");

  a_boot_led_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == ST_BOOT |-> !err_led && disp_code == DISP_SCROLL)
    else $error("boot animation with indicator on");

  a_boot_timeout: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == ST_BOOT && !os_up && sec_cnt == BOOT_TIMEOUT_S) |=> state == ST_FAIL && disp_code == DISP_BOOT_ERR)
    else $error("boot limit passed without boot error");

  a_version_value: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == ST_VERSION |-> disp_code == DISP_VERSION && disp_value == {20'h00000, FW_MAJOR, FW_MINOR})
    else $error("version display wrong");

  a_link_local_value: assert property (@(posedge clk_sys) disable iff (sys_rst)
    disp_code == DISP_LINK_LOCAL |-> disp_value == $past(link_local_addr))
    else $error("link-local display without its address");

  a_run_after_ver: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_enter_run |-> $past(sec_cnt) == VERSION_S && app_state == $past(start_app))
    else $error("run entered without version time or startup state");
endmodule // prs_sequencer
`default_nettype wire

// [tb/prs_op_model.sv]
`default_nettype none
module prs_op_model
  import prs_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Requests from the sequencer
  input wire logic halt_req,
  input wire logic store_req,
  // Operator and application side
  output logic btn_raw,
  output logic btn_enable,
  output logic halt_done,
  output logic store_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int lat = 0;
  int cnt = 0;

  initial
  begin
    btn_raw = 1'b0;
    btn_enable = 1'b1;
    halt_done = 1'b0;
    store_done = 1'b0;
  end

  // The application acknowledges with a one-cycle pulse after a chosen delay, so slow answers are exercised too.
  always @(posedge clk_sys)
  begin
    halt_done <= 1'b0;
    store_done <= 1'b0;
    if ((halt_req || store_req) && !halt_done && !store_done)
    begin
      cnt <= cnt + 1;
      if (cnt >= lat)
      begin
        halt_done <= halt_req;
        store_done <= store_req && !halt_req;
        cnt <= 0;
      end
    end
  end

  task automatic set_btn(input logic en, input logic v);
    @(posedge clk_sys);
    btn_enable <= en;
    btn_raw <= v;
  endtask
endmodule // prs_op_model
`default_nettype wire

// [tb/tb_prs_sequencer.sv]
`default_nettype none
module tb_prs_sequencer
  import prs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEB = 4;
  localparam int SEC = 20;
  logic clk_sys, sys_rst, img_check_done, img_check_ok, auth_done, auth_ok, os_up;
  logic addr_assigned, always_link_local, app_fault;
  logic [1:0] startup_state, cur_app, last_log;
  logic [31:0] config_addr, link_local_addr, disp_value;
  wire logic btn_raw, btn_enable, halt_done, store_done;
  logic err_led, halt_req, store_req, cfg_default, file_delete, module_reset, log_valid, ph, ps;
  logic [3:0] disp_code;
  logic [2:0] disp_digit;
  logic [1:0] app_state, log_code;
  int fail_count = 0;
  int num_checks = 0;
  int n_log, n_rst, n_cfg, n_del, n_halt, n_store;
  int holds[6] = '{5, 9, 10, 14, 15, 18};

  prs_sequencer #(.DEB_CYCLES(DEB), .SEC_CYCLES(SEC), .FW_MAJOR(4'h3), .FW_MINOR(8'h27)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .btn_raw(btn_raw), .btn_enable(btn_enable),
    .img_check_done(img_check_done), .img_check_ok(img_check_ok), .auth_done(auth_done), .auth_ok(auth_ok),
    .os_up(os_up), .addr_assigned(addr_assigned), .always_link_local(always_link_local),
    .startup_state(startup_state), .config_addr(config_addr), .link_local_addr(link_local_addr),
    .app_fault(app_fault), .halt_done(halt_done), .store_done(store_done), .err_led(err_led),
    .disp_code(disp_code), .disp_digit(disp_digit), .disp_value(disp_value), .app_state(app_state),
    .halt_req(halt_req), .store_req(store_req), .cfg_default(cfg_default), .file_delete(file_delete),
    .module_reset(module_reset), .log_valid(log_valid), .log_code(log_code));

  prs_op_model op (.clk_sys(clk_sys), .halt_req(halt_req), .store_req(store_req), .btn_raw(btn_raw),
    .btn_enable(btn_enable), .halt_done(halt_done), .store_done(store_done));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Pulses are counted at the falling edge, where registered outputs have settled.
  always @(negedge clk_sys)
  begin
    last_log = (log_valid === 1'b1) ? log_code : last_log;
    if (log_valid === 1'b1) n_log++;
    if (module_reset === 1'b1) n_rst++;
    if (cfg_default === 1'b1) n_cfg++;
    if (file_delete === 1'b1) n_del++;
    if (halt_req === 1'b1 && ph !== 1'b1) n_halt++;
    if (store_req === 1'b1 && ps !== 1'b1) n_store++;
    ph = halt_req;
    ps = store_req;
  end

  task automatic end_of_test();
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic wait_until(input int sel, input int bound);
    int k;
    k = 0;
    while (!((sel == 0) ? n_log > 0 : n_rst > 0) && k < bound)
    begin
      @(negedge clk_sys);
      k++;
    end
    if (k >= bound)
    begin
      chk("wait event", 32'h1, 32'h0);
      end_of_test();
    end
  endtask

  function automatic logic [3:0] e_code(input int h);
    if (h >= 15) return DISP_FACTORY_PEND;
    if (h == 10) return DISP_CONFIG_PEND;
    if (h == 5) return DISP_RESET_PEND;
    return DISP_COUNT;
  endfunction

  function automatic logic [2:0] e_dig(input int h);
    if (h >= 15 || h % 5 == 0) return 3'h0;
    return 3'(5 - h % 5);
  endfunction

  function automatic int e_act(input int h);
    return (h < 5) ? 0 : (h < 10) ? 1 : (h < 15) ? 2 : 3;
  endfunction

  task automatic do_reset();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask

  // Mode 0 boots fully, 1 fails the image check, 2 fails authenticity, 3 never brings the OS up.
  task automatic boot(input int mode, input bit dflt);
    int n;
    logic ll;
    @(posedge clk_sys);
    startup_state <= 2'($urandom_range(3, 0));
    addr_assigned <= 1'($urandom);
    always_link_local <= 1'($urandom);
    config_addr <= $urandom;
    link_local_addr <= $urandom;
    img_check_ok <= (mode != 1);
    img_check_done <= 1'b1;
    @(posedge clk_sys);
    img_check_done <= 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("err_led power", 32'h1, {31'h0, err_led});
    if (mode == 1)
    begin
      repeat (SEC) @(negedge clk_sys);
      chk("disp img fail", 32'h0, {28'h0, disp_code});
      chk("err_led img fail", 32'h1, {31'h0, err_led});
      return;
    end
    @(posedge clk_sys);
    auth_ok <= (mode != 2);
    auth_done <= 1'b1;
    @(posedge clk_sys);
    auth_done <= 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("err_led auth", {31'h0, mode == 2}, {31'h0, err_led});
    if (mode == 2) return;
    chk("disp boot", DISP_SCROLL, {28'h0, disp_code});
    if (mode == 3)
    begin
      repeat (30 * SEC - 10) @(negedge clk_sys);
      chk("disp before timeout", DISP_SCROLL, {28'h0, disp_code});
      repeat (15) @(negedge clk_sys);
      chk("disp timeout", DISP_BOOT_ERR, {28'h0, disp_code});
      chk("err_led timeout", 32'h1, {31'h0, err_led});
      return;
    end
    @(posedge clk_sys);
    os_up <= 1'b1;
    @(posedge clk_sys);
    os_up <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("disp version", DISP_VERSION, {28'h0, disp_code});
    chk("version value", 32'h0000_0327, disp_value);
    n = 0;
    while (disp_code === DISP_VERSION && n < 3 * SEC)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("version time", 32'h1, {31'h0, n >= 2 * SEC - 4 && n <= 2 * SEC + 1});
    ll = !addr_assigned || always_link_local;
    chk("disp addr", ll ? DISP_LINK_LOCAL : DISP_ADDR, {28'h0, disp_code});
    chk("addr value", ll ? link_local_addr : config_addr, disp_value);
    cur_app = dflt ? APP_STOP : startup_state;
    chk("app_state start", {30'h0, cur_app}, {30'h0, app_state});
  endtask

  // Holds the button for h and a half seconds, checking the panel at the middle of each second.
  task automatic press(input int h, input logic en);
    int a;
    bit live;
    logic [3:0] rc;
    a = en ? e_act(h) : 0;
    live = (cur_app == APP_RUN || cur_app == APP_LOGIC_HALT);
    rc = disp_code;
    n_log = 0;
    n_rst = 0;
    n_cfg = 0;
    n_del = 0;
    n_halt = 0;
    n_store = 0;
    op.lat = $urandom_range(6, 0);
    op.set_btn(en, 1'b1);
    repeat (DEB + SEC / 2) @(negedge clk_sys);
    for (int k = 1; k <= h; k++)
    begin
      repeat (SEC) @(negedge clk_sys);
      chk("disp hold", en ? e_code(k) : rc, {28'h0, disp_code});
      chk("digit hold", en ? e_dig(k) : 3'h0, {29'h0, disp_digit});
    end
    op.set_btn(1'b1, 1'b0);
    if (!en || a == 0)
    begin
      repeat (DEB + SEC) @(negedge clk_sys);
      chk("log count", {31'h0, en}, n_log);
      chk("reset count", 32'h0, n_rst);
      if (en)
        chk("abort code", 32'h0, {30'h0, last_log});
      return;
    end
    wait_until(0, DEB + 10);
    chk("log code", a, {30'h0, last_log});
    wait_until(1, 200);
    chk("halt", {31'h0, live}, n_halt);
    chk("store", {31'h0, live && a >= 2}, n_store);
    chk("cfg default", {31'h0, a >= 2}, n_cfg);
    chk("file delete", {31'h0, a == 3}, n_del);
    repeat (2) @(negedge clk_sys);
    chk("err_led restart", 32'h1, {31'h0, err_led});
    boot(0, a >= 2);
  endtask

  initial
  begin
    sys_rst = 1'b1;
    {img_check_done, img_check_ok, auth_done, auth_ok, os_up, app_fault} = 6'h0;
    {addr_assigned, always_link_local} = 2'h0;
    startup_state = 2'h1;
    config_addr = 32'h0;
    link_local_addr = 32'h0;
    {ph, ps, last_log} = 4'h0;
    void'($urandom(32'h74BD6CE6));
    @(negedge clk_sys);
    chk("err_led reset", 32'h1, {31'h0, err_led});
    chk("app reset", 32'h0, {30'h0, app_state});
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int m = 1; m <= 3; m++)
    begin
      boot(m, 1'b0);
      do_reset();
    end
    boot(0, 1'b0);
    press(16, 1'b0);
    press(3, 1'b1);
    press(7, 1'b1);
    @(posedge clk_sys);
    app_fault <= 1'b1;
    @(posedge clk_sys);
    app_fault <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("app fault", APP_ERROR, {30'h0, app_state});
    cur_app = APP_ERROR;
    press(6, 1'b1);
    foreach (holds[i])
      press(holds[i], 1'b1);
    repeat (3)
      press($urandom_range(17, 0), 1'b1);
    end_of_test();
  end
endmodule // tb_prs_sequencer
`default_nettype wire
